// ---- logic/tap_pkg.sv ----
// Operation
// R1: A port carries traffic only after its enable: config bit or entry sequence.
// R2: Blank device reaches the 4-wire port with no configuration at all.
// R3: Only the test clock advances the TAP and shifts its registers.
// R4: The TAP samples mode select on each rising test clock edge.
// R5: Test data in is taken on rising edges, only in shift states.
// R6: Test data out changes on the falling test clock edge.
// R7: Test data out is driven only while shifting, else released.
// R8: In 2-wire mode the serial clock steps the TAP and shifts registers.
// R9: The serial data line carries shift data both ways and mode select.
// R10: The serial data line is sampled on falling serial clock edges.
// R11: A converter turns the 2-wire port into 4-wire TAP signals.
// R12: Only the enabled port drives the TAP; the other is ignored.
package tap_pkg;

	// ---------------------------------------------------------------
	// Register widths and values
	// ---------------------------------------------------------------
	localparam int IR_W = 5;
	localparam int DR_W = 32;
	localparam logic [4:0] INSN_IDCODE = 5'h01;
	localparam logic [4:0] INSN_DATA = 5'h07;
	localparam logic [4:0] INSN_BYPASS = 5'h1F;
	localparam logic [4:0] IR_RESET = 5'h01;
	localparam logic [4:0] IR_CAPTURE = 5'h01;
	// Identification value is arbitrary.
	localparam logic [31:0] ID_CODE = 32'h0000_1001;
	localparam logic [31:0] DR_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Serial slot phases, one TAP step per four serial clocks
	// ---------------------------------------------------------------
	localparam logic [1:0] PH_TDI = 2'h0;
	localparam logic [1:0] PH_TMS = 2'h1;
	localparam logic [1:0] PH_TDO = 2'h2;
	localparam logic [1:0] PH_TURN = 2'h3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h3,
		ST_CAP_DR = 4'h2,
		ST_SH_DR = 4'h6,
		ST_EX1_DR = 4'h7,
		ST_PAU_DR = 4'h5,
		ST_EX2_DR = 4'h4,
		ST_UPD_DR = 4'hC,
		ST_SEL_IR = 4'hD,
		ST_CAP_IR = 4'hF,
		ST_SH_IR = 4'hE,
		ST_EX1_IR = 4'hA,
		ST_PAU_IR = 4'hB,
		ST_EX2_IR = 4'h9,
		ST_UPD_IR = 4'h8
	} tap_state_t;

	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_JTAG = 2'b01,
		MODE_SERIAL = 2'b11
	} port_mode_t;

	localparam port_mode_t MODE_RESET = MODE_JTAG;

	typedef struct packed {
		logic is_ir;
		logic [31:0] word;
	} update_t;

	localparam update_t UPDATE_RESET = 33'h0_0000_0000;

endpackage

// ---- logic/tap_fsm.sv ----
module tap_fsm
	import tap_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Step control
	input wire logic step,
	input wire logic tms,
	// State
	output tap_state_t state
);

	tap_state_t state_r;
	tap_state_t state_nxt;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		if (step) begin
			unique case (state_r)
				ST_RESET: state_nxt = tms ? ST_RESET : ST_IDLE;
				ST_IDLE: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
				ST_SH_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
				ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
				ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
				ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
				ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: state_nxt = tms ? ST_RESET : ST_CAP_IR;
				ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
				ST_SH_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
				ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
				ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
				ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
				ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_IDLE;
			endcase
		end
	end

	// R4: mode select on rising edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state = state_r;

endmodule

// ---- logic/serial_converter.sv ----
module serial_converter
	import tap_pkg::*;
(
	// Serial clock and reset
	input wire logic clk,
	input wire logic rst,
	// Enable from the system side, asynchronous level
	input wire logic serial_en,
	// Serial data pin
	input wire logic data_in,
	output logic data_out,
	output logic data_oe,
	// Equivalent 4-wire signals
	output logic tms,
	output logic tdi,
	output logic step,
	input wire logic tdo_bit,
	input wire logic tdo_shift
);

	logic en_meta_r;
	logic en_r;
	logic [1:0] phase_r;
	logic [1:0] phase_nxt;
	logic tms_r;
	logic tms_nxt;
	logic tdi_r;
	logic tdi_nxt;
	logic step_r;
	logic step_nxt;
	logic out_r;
	logic out_nxt;
	logic oe_r;
	logic oe_nxt;

	// ---------------------------------------------------------------
	// Slot sequencing
	// ---------------------------------------------------------------
	// R11: one TAP step per four-clock slot
	always_comb begin
		phase_nxt = en_r ? phase_r + 2'h1 : PH_TDI;
		tdi_nxt = tdi_r;
		tms_nxt = tms_r;
		step_nxt = 1'b0;
		out_nxt = out_r;
		oe_nxt = 1'b0;
		if (en_r) begin
			unique case (phase_r)
				// R9: data bit in from the line
				PH_TDI: tdi_nxt = data_in;
				PH_TMS: begin
					// R9: mode select from the same line
					tms_nxt = data_in;
					step_nxt = 1'b1;
				end
				PH_TDO: begin
					// R7: line driven only for shifted data
					out_nxt = tdo_bit;
					oe_nxt = tdo_shift;
				end
				PH_TURN: oe_nxt = 1'b0;
			endcase
		end
	end

	// R10: sampled on falling serial clock
	always_ff @(negedge clk or posedge rst) begin
		if (rst) begin
			en_meta_r <= 1'b0;
			en_r <= 1'b0;
			phase_r <= PH_TDI;
			tdi_r <= 1'b0;
			tms_r <= 1'b1;
			step_r <= 1'b0;
			out_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			en_meta_r <= serial_en;
			en_r <= en_meta_r;
			phase_r <= phase_nxt;
			tdi_r <= tdi_nxt;
			tms_r <= tms_nxt;
			step_r <= step_nxt;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign tms = tms_r;
	assign tdi = tdi_r;
	assign step = step_r;
	assign data_out = out_r;
	assign data_oe = oe_r;

endmodule

// ---- logic/tap_front_end.sv ----
module tap_front_end
	import tap_pkg::*;
(
	// System clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Port enables
	input wire logic JTAG_CFG_BIT,
	input wire logic SERIAL_ENTRY,
	// 4-wire port
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	output logic TDO,
	output logic TDO_OE,
	// 2-wire port
	input wire logic PROGRAM_SERIAL_CLOCK,
	input wire logic PROGRAM_SERIAL_DATA_IN,
	output logic PROGRAM_SERIAL_DATA_OUT,
	output logic PROGRAM_SERIAL_DATA_OE,
	// System results
	output update_t UPD_WORD,
	output logic UPD_STROBE,
	output logic TAP_IN_RESET
);

	// ---------------------------------------------------------------
	// System domain: port selection
	// ---------------------------------------------------------------
	logic cfg_meta_r;
	logic cfg_r;
	logic entry_meta_r;
	logic entry_r;
	port_mode_t mode_r;
	port_mode_t mode_nxt;

	// R1: a port is usable only once enabled
	always_comb begin
		if (entry_r) begin
			mode_nxt = MODE_SERIAL;
		end else if (cfg_r) begin
			mode_nxt = MODE_JTAG;
		end else begin
			mode_nxt = MODE_OFF;
		end
	end

	// R2: 4-wire port is on out of reset
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cfg_meta_r <= 1'b1;
			cfg_r <= 1'b1;
			entry_meta_r <= 1'b0;
			entry_r <= 1'b0;
			mode_r <= MODE_RESET;
		end else begin
			cfg_meta_r <= JTAG_CFG_BIT;
			cfg_r <= cfg_meta_r;
			entry_meta_r <= SERIAL_ENTRY;
			entry_r <= entry_meta_r;
			mode_r <= mode_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Test clock selection
	// ---------------------------------------------------------------
	// The select is quasi-static: software must change the port only
	// while both link clocks are idle, or a runt edge may step the TAP.
	logic tap_clk;

	// R12: only the enabled port clocks the TAP
	always_comb begin
		unique case (mode_r)
			MODE_SERIAL: tap_clk = PROGRAM_SERIAL_CLOCK;
			MODE_JTAG: tap_clk = TCK;
			default: tap_clk = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// 2-wire to 4-wire conversion
	// ---------------------------------------------------------------
	logic conv_tms;
	logic conv_tdi;
	logic conv_step;
	logic tdo_r;
	logic shift_out_r;
	logic serial_sel;

	assign serial_sel = (mode_r == MODE_SERIAL);

	// R11: converter feeds the shared TAP
	serial_converter u_conv (
		.clk(PROGRAM_SERIAL_CLOCK),
		.rst(SYS_RST),
		.serial_en(serial_sel),
		.data_in(PROGRAM_SERIAL_DATA_IN),
		.data_out(PROGRAM_SERIAL_DATA_OUT),
		.data_oe(PROGRAM_SERIAL_DATA_OE),
		.tms(conv_tms),
		.tdi(conv_tdi),
		.step(conv_step),
		.tdo_bit(tdo_r),
		.tdo_shift(shift_out_r)
	);

	// ---------------------------------------------------------------
	// Link domain: input selection
	// ---------------------------------------------------------------
	logic ser_meta_r;
	logic ser_lk_r;
	logic tms_sel;
	logic tdi_sel;
	logic step_sel;

	// R12: the inactive port's pins are ignored
	always_comb begin
		tms_sel = ser_lk_r ? conv_tms : TMS;
		tdi_sel = ser_lk_r ? conv_tdi : TDI;
		// R8: serial clock steps the TAP once per slot
		step_sel = ser_lk_r ? conv_step : 1'b1;
	end

	// ---------------------------------------------------------------
	// TAP controller
	// ---------------------------------------------------------------
	tap_state_t state;

	// R3: TAP runs on the test clock alone
	tap_fsm u_fsm (
		.clk(tap_clk),
		.rst(SYS_RST),
		.step(step_sel),
		.tms(tms_sel),
		.state(state)
	);

	// ---------------------------------------------------------------
	// Instruction and data registers
	// ---------------------------------------------------------------
	logic [IR_W-1:0] ir_sh_r;
	logic [IR_W-1:0] ir_sh_nxt;
	logic [IR_W-1:0] ir_r;
	logic [IR_W-1:0] ir_nxt;
	logic [DR_W-1:0] dr_sh_r;
	logic [DR_W-1:0] dr_sh_nxt;
	logic [DR_W-1:0] data_r;
	logic [DR_W-1:0] data_nxt;
	logic byp_r;
	logic byp_nxt;
	update_t hold_r;
	update_t hold_nxt;
	logic tgl_r;
	logic tgl_nxt;

	always_comb begin
		ir_sh_nxt = ir_sh_r;
		ir_nxt = ir_r;
		dr_sh_nxt = dr_sh_r;
		data_nxt = data_r;
		byp_nxt = byp_r;
		hold_nxt = hold_r;
		tgl_nxt = tgl_r;
		if (step_sel) begin
			unique case (state)
				ST_RESET: ir_nxt = IR_RESET;
				ST_CAP_IR: ir_sh_nxt = IR_CAPTURE;
				// R5: data in taken only while shifting
				ST_SH_IR: ir_sh_nxt = {tdi_sel, ir_sh_r[IR_W-1:1]};
				ST_UPD_IR: begin
					ir_nxt = ir_sh_r;
					hold_nxt = {1'b1, 27'h0, ir_sh_r};
					tgl_nxt = ~tgl_r;
				end
				ST_CAP_DR: begin
					unique case (ir_r)
						INSN_IDCODE: dr_sh_nxt = ID_CODE;
						INSN_DATA: dr_sh_nxt = data_r;
						default: byp_nxt = 1'b0;
					endcase
				end
				ST_SH_DR: begin
					// R5: data in taken only while shifting
					if (ir_r == INSN_IDCODE || ir_r == INSN_DATA) begin
						dr_sh_nxt = {tdi_sel, dr_sh_r[DR_W-1:1]};
					end else begin
						byp_nxt = tdi_sel;
					end
				end
				ST_UPD_DR: begin
					if (ir_r == INSN_DATA) begin
						data_nxt = dr_sh_r;
						hold_nxt = {1'b0, dr_sh_r};
						tgl_nxt = ~tgl_r;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge tap_clk or posedge SYS_RST) begin
		if (SYS_RST) begin
			ser_meta_r <= 1'b0;
			ser_lk_r <= 1'b0;
			ir_sh_r <= IR_RESET;
			ir_r <= IR_RESET;
			dr_sh_r <= DR_RESET;
			data_r <= DR_RESET;
			byp_r <= 1'b0;
			hold_r <= UPDATE_RESET;
			tgl_r <= 1'b0;
		end else begin
			ser_meta_r <= serial_sel;
			ser_lk_r <= ser_meta_r;
			ir_sh_r <= ir_sh_nxt;
			ir_r <= ir_nxt;
			dr_sh_r <= dr_sh_nxt;
			data_r <= data_nxt;
			byp_r <= byp_nxt;
			hold_r <= hold_nxt;
			tgl_r <= tgl_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Test data out
	// ---------------------------------------------------------------
	logic tdo_nxt;
	logic shift_nxt;
	logic tdo_oe_r;
	logic tdo_oe_nxt;

	always_comb begin
		if (state == ST_SH_IR) begin
			tdo_nxt = ir_sh_r[0];
		end else if (ir_r == INSN_IDCODE || ir_r == INSN_DATA) begin
			tdo_nxt = dr_sh_r[0];
		end else begin
			tdo_nxt = byp_r;
		end
		shift_nxt = (state == ST_SH_IR) || (state == ST_SH_DR);
		// R7: pin released outside shift states
		tdo_oe_nxt = shift_nxt && !ser_lk_r;
	end

	// R6: data out changes on falling edge
	always_ff @(negedge tap_clk or posedge SYS_RST) begin
		if (SYS_RST) begin
			tdo_r <= 1'b0;
			shift_out_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tdo_r <= tdo_nxt;
			shift_out_r <= shift_nxt;
			tdo_oe_r <= tdo_oe_nxt;
		end
	end

	assign TDO = tdo_r;
	assign TDO_OE = tdo_oe_r;

	// ---------------------------------------------------------------
	// Crossing of updates into the system domain
	// ---------------------------------------------------------------
	// The held word is written on the same edge as the toggle, two sync stages before the toggle
	// arrives, so it may be loaded as a whole once the toggle is seen.
	logic tgl_meta_r;
	logic tgl_s_r;
	logic tgl_d_r;
	logic rst_meta_r;
	logic rst_s_r;
	update_t upd_r;
	update_t upd_nxt;
	logic strobe_nxt;
	logic strobe_r;

	always_comb begin
		strobe_nxt = tgl_s_r ^ tgl_d_r;
		upd_nxt = strobe_nxt ? hold_r : upd_r;
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tgl_meta_r <= 1'b0;
			tgl_s_r <= 1'b0;
			tgl_d_r <= 1'b0;
			rst_meta_r <= 1'b1;
			rst_s_r <= 1'b1;
			upd_r <= UPDATE_RESET;
			strobe_r <= 1'b0;
		end else begin
			tgl_meta_r <= tgl_r;
			tgl_s_r <= tgl_meta_r;
			tgl_d_r <= tgl_s_r;
			rst_meta_r <= (state == ST_RESET);
			rst_s_r <= rst_meta_r;
			upd_r <= upd_nxt;
			strobe_r <= strobe_nxt;
		end
	end

	assign UPD_WORD = upd_r;
	assign UPD_STROBE = strobe_r;
	assign TAP_IN_RESET = rst_s_r;

endmodule

// ---- testbench/tap_front_end_properties.sv ----
module tap_front_end_properties
	import tap_pkg::*;
(
	// System side
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic JTAG_CFG_BIT,
	input wire logic SERIAL_ENTRY,
	input wire update_t UPD_WORD,
	input wire logic UPD_STROBE,
	input wire logic TAP_IN_RESET,
	// Link side
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDO,
	input wire logic TDO_OE,
	input wire logic PROGRAM_SERIAL_CLOCK,
	input wire logic PROGRAM_SERIAL_DATA_OE
);
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Port behaviour
	// ---------------------------------------------------------------
	// A link clock low phase outlasts one system period, so a change seen
	// while the link clock is high must have come from a rising edge.
	a_strobe_pulse: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) UPD_STROBE |=> !UPD_STROBE)
		else $error("update strobe longer than one cycle");
	a_word_hold: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) !UPD_STROBE |-> $stable(UPD_WORD))
		else $error("update word moved without strobe");
	a_oe_excl: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) !(TDO_OE && PROGRAM_SERIAL_DATA_OE))
		else $error("both ports drive at once");
	a_tdo_fall: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) $changed(TDO) |-> !TCK)
		else $error("test data out moved off falling edge");
	a_tdo_oe_fall: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) $changed(TDO_OE) |-> !TCK)
		else $error("test data out enable moved off falling edge");
	a_sd_oe_fall: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST)
		$changed(PROGRAM_SERIAL_DATA_OE) |-> !PROGRAM_SERIAL_CLOCK)
		else $error("serial drive moved off falling edge");
	a_tap_reset: assert property (@(posedge TCK)
		disable iff (SYS_RST || SERIAL_ENTRY || !JTAG_CFG_BIT)
		TMS [*8] |-> TAP_IN_RESET)
		else $error("mode select ones did not reset the TAP");
	a_tdo_serial: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) SERIAL_ENTRY [*8] |-> !TDO_OE)
		else $error("test data out driven in serial mode");
	a_sd_idle: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST)
		!SERIAL_ENTRY [*8] |-> !PROGRAM_SERIAL_DATA_OE)
		else $error("serial line driven while not entered");
	a_tdo_off: assert property (@(posedge SYS_CLK)
		disable iff (SYS_RST) !JTAG_CFG_BIT [*8] |-> !TDO_OE)
		else $error("test data out driven while disabled");
endmodule

bind tap_front_end tap_front_end_properties u_props (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
	.JTAG_CFG_BIT(JTAG_CFG_BIT), .SERIAL_ENTRY(SERIAL_ENTRY),
	.UPD_WORD(UPD_WORD), .UPD_STROBE(UPD_STROBE),
	.TAP_IN_RESET(TAP_IN_RESET), .TCK(TCK), .TMS(TMS), .TDO(TDO),
	.TDO_OE(TDO_OE), .PROGRAM_SERIAL_CLOCK(PROGRAM_SERIAL_CLOCK),
	.PROGRAM_SERIAL_DATA_OE(PROGRAM_SERIAL_DATA_OE)
);

// ---- testbench/prog_tool.sv ----
module prog_tool
	import tap_pkg::*;
(
	// Port choice
	input wire logic serial_sel,
	// 4-wire side
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_line,
	// 2-wire side
	output logic sclk,
	output logic sd_drv,
	output logic sd_oe,
	input wire logic sd_line
);
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------------
	// Link stepping
	// ---------------------------------------------------------------
	// Both link clocks rest low between steps and run at 48 ns inside.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		sclk = 1'b0;
		sd_drv = 1'b0;
		sd_oe = 1'b0;
	end

	task automatic pulse(output logic s);
		#12 sclk = 1'b1;
		#12 s = sd_line;
		#12 sclk = 1'b0;
		#12;
	endtask

	task automatic step(input logic ms, input logic di, output logic dout);
		logic s;
		if (serial_sel) begin
			// data then mode select on one line
			sd_oe = 1'b1;
			sd_drv = di;
			pulse(s);
			sd_drv = ms;
			pulse(s);
			// line released for the device answer
			sd_oe = 1'b0;
			pulse(s);
			pulse(dout);
		end else begin
			tms = ms;
			tdi = di;
			#12 tck = 1'b1;
			dout = tdo_line;
			#24 tck = 1'b0;
			#12;
		end
	endtask

	task automatic sync_pulses();
		logic s;
		sd_oe = 1'b0;
		pulse(s);
		pulse(s);
	endtask

	task automatic tap_reset();
		logic d;
		repeat (8) step(1'b1, 1'b0, d);
	endtask

	// Shifts n bits LSB first from Idle or Reset and returns to Idle.
	task automatic shift(input logic ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic d;
		dout = '0;
		step(1'b0, 1'b0, d);
		step(1'b1, 1'b0, d);
		if (ir) step(1'b1, 1'b0, d);
		step(1'b0, 1'b0, d);
		step(1'b0, 1'b0, d);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], d);
			dout[i] = d;
		end
		step(1'b1, 1'b0, d);
		step(1'b0, 1'b0, d);
	endtask
endmodule

// ---- testbench/tap_front_end_tb.sv ----
module tap_front_end_tb
	import tap_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

`define CHK(g, e) check((g) === (e));

	// ---------------------------------------------------------------
	// Harness
	// ---------------------------------------------------------------
	logic sys_clk, sys_rst, cfg_bit, entry, serial_sel, float_r;
	logic tck, tms, tdi, tdo, tdo_oe, tdo_line;
	logic sclk, sd_drv, sd_oe, dev_d, dev_oe, sd_line;
	logic upd_strobe, tap_rst;
	update_t upd_word, upd_last;
	int upd_seen, mismatches, n_checks;

	// A released line must not keep its last level, so it wanders.
	assign tdo_line = tdo_oe ? tdo : float_r;
	assign sd_line = sd_oe ? sd_drv : (dev_oe ? dev_d : float_r);

	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	initial float_r = 1'b0;
	always @(posedge sys_clk) float_r <= ~float_r;
	initial upd_seen = 0;
	always @(posedge sys_clk) begin
		if (upd_strobe === 1'b1) begin
			upd_seen <= upd_seen + 1;
			upd_last <= upd_word;
		end
	end

	tap_front_end dut (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
		.JTAG_CFG_BIT(cfg_bit), .SERIAL_ENTRY(entry),
		.TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
		.PROGRAM_SERIAL_CLOCK(sclk), .PROGRAM_SERIAL_DATA_IN(sd_line),
		.PROGRAM_SERIAL_DATA_OUT(dev_d), .PROGRAM_SERIAL_DATA_OE(dev_oe),
		.UPD_WORD(upd_word), .UPD_STROBE(upd_strobe),
		.TAP_IN_RESET(tap_rst)
	);

	prog_tool tool (
		.serial_sel(serial_sel), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_line(tdo_line), .sclk(sclk), .sd_drv(sd_drv),
		.sd_oe(sd_oe), .sd_line(sd_line)
	);

	task automatic check(input bit ok);
		n_checks++;
		if (!ok) begin
			mismatches++;
			$display("MISMATCH at %0t: value differs", $time);
		end
	endtask

	task automatic wait_sys(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic upd_chk(input int n0, input update_t exp);
		wait_sys(6);
		`CHK(upd_seen, n0 + 1)
		`CHK(upd_last, exp)
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_jtag_id();
		logic [31:0] q;
		tool.tap_reset();
		wait_sys(6);
		`CHK(tap_rst, 1'b1)
		tool.shift(1'b1, IR_W, 32'(INSN_IDCODE), q);
		`CHK(q[4:0], IR_CAPTURE)
		tool.shift(1'b0, DR_W, 32'hA5C3_0F96, q);
		`CHK(q, ID_CODE)
		`CHK(tap_rst, 1'b0)
		`CHK(tdo_oe, 1'b0)
		$display("test jtag_idcode done");
	endtask

	task automatic t_jtag_data();
		int n;
		logic [31:0] q;
		n = upd_seen;
		tool.shift(1'b1, IR_W, 32'(INSN_DATA), q);
		upd_chk(n, update_t'({1'b1, 32'(INSN_DATA)}));
		tool.shift(1'b0, DR_W, 32'h1234_5678, q);
		upd_chk(n + 1, update_t'({1'b0, 32'h1234_5678}));
		tool.shift(1'b0, DR_W, 32'h0F0F_00FF, q);
		`CHK(q, 32'h1234_5678)
		tool.shift(1'b1, IR_W, 32'(INSN_BYPASS), q);
		wait_sys(6);
		n = upd_seen;
		tool.shift(1'b0, DR_W, 32'h8000_0003, q);
		wait_sys(6);
		`CHK(q, 32'h0000_0006)
		`CHK(upd_seen, n)
		$display("test jtag_data done");
	endtask

	task automatic t_cfg_off();
		logic d;
		@(posedge sys_clk) cfg_bit <= 1'b0;
		wait_sys(5);
		repeat (8) tool.step(1'b1, 1'b0, d);
		wait_sys(6);
		`CHK(tap_rst, 1'b0)
		@(posedge sys_clk) cfg_bit <= 1'b1;
		wait_sys(5);
		// Reset from Idle, so the mode select ones really move the TAP.
		tool.tap_reset();
		wait_sys(6);
		`CHK(tap_rst, 1'b1)
		$display("test port_disabled done");
	endtask

	task automatic t_serial();
		int n;
		logic [31:0] q;
		logic d;
		@(posedge sys_clk) entry <= 1'b1;
		wait_sys(5);
		// Zeros on the idle 4-wire port would leave reset if obeyed.
		repeat (8) tool.step(1'b0, 1'b0, d);
		wait_sys(6);
		`CHK(tap_rst, 1'b1)
		@(posedge sys_clk) serial_sel <= 1'b1;
		@(posedge sys_clk);
		tool.sync_pulses();
		tool.tap_reset();
		wait_sys(6);
		`CHK(tap_rst, 1'b1)
		n = upd_seen;
		tool.shift(1'b1, IR_W, 32'(INSN_DATA), q);
		`CHK(q[4:0], IR_CAPTURE)
		upd_chk(n, update_t'({1'b1, 32'(INSN_DATA)}));
		tool.shift(1'b0, DR_W, 32'hC0DE_5A17, q);
		upd_chk(n + 1, update_t'({1'b0, 32'hC0DE_5A17}));
		tool.shift(1'b0, DR_W, 32'h0000_0000, q);
		`CHK(q, 32'hC0DE_5A17)
		@(posedge sys_clk) serial_sel <= 1'b0;
		entry <= 1'b0;
		wait_sys(5);
		$display("test serial_port done");
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		final_report();
	end

	initial begin
		mismatches = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		cfg_bit = 1'b1;
		entry = 1'b0;
		serial_sel = 1'b0;
		wait_sys(4);
		sys_rst <= 1'b0;
		wait_sys(4);
		t_jtag_id();
		t_jtag_data();
		t_cfg_off();
		t_serial();
		final_report();
	end
endmodule
